/* File: hw/ihbp_pkg.sv */
// shared constants for the indexed host bus port, both ends
// assumes one 125 MHz clock feeds both ends
package ihbp_pkg;
   // ****************************************
   // bus widths and register locations
   // ****************************************
   localparam int DATA_W = 8;
   localparam int IRQ_W = 8;
   localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h0D;
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0E;
   localparam logic [7:0] ROLE_CTRL_ADDR = 8'h0F;
   localparam int ROLE_BIT = 0;
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
   localparam logic ROLE_RESET = 1'b0;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int STROBE_MIN_NS = 65;
   localparam int STROBE_GAP_NS = 85;
   localparam int RESET_HOLD_CYC = 16;
   localparam int RESET_WAIT_CYC = 16;
   // least times round up
   localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = (STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : ihbp_pkg

/* File: hw/ihbp_if.sv */
// pins between the external processor and the port
// assumes no bus keeper: an undriven data bus reads all ones
`timescale 1ns/1ns
`default_nettype none
interface ihbp_if;
   logic chip_select_n;
   logic read_strobe_n;
   logic write_strobe_n;
   logic pointer_or_data_select;
   logic reset_n_in;
   logic role_select;
   logic irq_out;
   logic [7:0] data_from_host;
   logic data_host_oe;
   logic [7:0] data_from_dev;
   logic data_dev_oe;
   logic [7:0] data_bus;
   // ****************************************
   // resolved data bus level
   // ****************************************
   assign data_bus = data_dev_oe ? data_from_dev :
                     (data_host_oe ? data_from_host : 8'hFF);
   modport dev (
      input chip_select_n, read_strobe_n, write_strobe_n,
      input pointer_or_data_select, reset_n_in, role_select, data_bus,
      output irq_out, data_from_dev, data_dev_oe
   );
   modport host (
      output chip_select_n, read_strobe_n, write_strobe_n,
      output pointer_or_data_select, reset_n_in, role_select,
      output data_from_host, data_host_oe,
      input irq_out, data_bus
   );
endinterface : ihbp_if
`default_nettype wire

/* File: hw/ihbp_host.sv */
// processor end: runs reset, then single reads and writes on the pins
// assumes the device end samples pins through two flip-flops
`timescale 1ns/1ns
`default_nettype none
module ihbp_host
   import ihbp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   ihbp_if.host pins,
   input wire logic role_strap,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic cmd_sel,
   input wire logic [7:0] cmd_wdata,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic link_ready,
   output logic irq_seen
);
   typedef enum logic [2:0] {HOLD_RST, WAIT_RST, IDLE, ACTIVE, GAP} ihbp_hst_type;
   ihbp_hst_type st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic wr_q, wr_d;
   logic sel_q, sel_d;
   logic [7:0] wd_q, wd_d;
   logic rv_q, rv_d;
   logic [7:0] rd_q, rd_d;
   logic [8:0] sy1_q, sy2_q;

   // ****************************************
   // input synchronisers
   // ****************************************
   always_ff @(posedge clk) begin
      sy1_q <= {pins.irq_out, pins.data_bus};
      sy2_q <= sy1_q;
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q + 8'h01;
      wr_d = wr_q;
      sel_d = sel_q;
      wd_d = wd_q;
      rv_d = 1'b0;
      rd_d = rd_q;
      unique case (st_q)
         HOLD_RST: begin
            if (cnt_q == 8'(RESET_HOLD_CYC - 1)) begin
               st_d = WAIT_RST;
               cnt_d = 8'h00;
            end
         end
         WAIT_RST: begin
            if (cnt_q == 8'(RESET_WAIT_CYC - 1)) begin
               st_d = IDLE;
            end
         end
         IDLE: begin
            cnt_d = 8'h00;
            if (cmd_valid) begin
               st_d = ACTIVE;
               wr_d = cmd_write;
               sel_d = cmd_sel;
               wd_d = cmd_wdata;
            end
         end
         ACTIVE: begin
            // read data is sampled late, after device and input sync lag
            if (cnt_q == 8'(STROBE_CYC - 1)) begin
               st_d = GAP;
               cnt_d = 8'h00;
               if (!wr_q) begin
                  rv_d = 1'b1;
                  rd_d = sy2_q[7:0];
               end
            end
         end
         GAP: begin
            if (cnt_q == 8'(GAP_CYC - 1)) begin
               st_d = IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= HOLD_RST;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         sel_q <= 1'b0;
         wd_q <= 8'h00;
         rv_q <= 1'b0;
         rd_q <= 8'h00;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         sel_q <= sel_d;
         wd_q <= wd_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
      end
   end

   // ****************************************
   // pin drive
   // ****************************************
   // chip select spans strobe and gap so the device sees it around the edge
   // select toggles per access; a sole device may also see it held low
   assign pins.chip_select_n = !(st_q == ACTIVE || st_q == GAP);
   assign pins.read_strobe_n = !(st_q == ACTIVE && !wr_q);
   assign pins.write_strobe_n = !(st_q == ACTIVE && wr_q);
   // registered select stands in for an external address latch
   assign pins.pointer_or_data_select = sel_q;
   assign pins.data_from_host = wd_q;
   assign pins.data_host_oe = wr_q && (st_q == ACTIVE || st_q == GAP);
   assign pins.reset_n_in = (st_q != HOLD_RST);
   assign pins.role_select = role_strap;
   assign cmd_ready = (st_q == IDLE);
   assign rsp_valid = rv_q;
   assign rsp_data = rd_q;
   assign link_ready = (st_q != HOLD_RST) && (st_q != WAIT_RST);
   assign irq_seen = sy2_q[8];
endmodule : ihbp_host
`default_nettype wire

/* File: hw/ihbp_device.sv */
// device end: pointer-indexed register and memory port on async pins
// assumes pins are asynchronous to clk and strobes last several cycles
`timescale 1ns/1ns
`default_nettype none
module ihbp_device
   import ihbp_pkg::*;
#(
   parameter int MEM_DEPTH = 256
)(
   input wire logic clk,
   input wire logic rst_n,
   ihbp_if.dev pins,
   input wire logic [IRQ_W-1:0] event_pulse,
   output logic role_peripheral,
   output logic [IRQ_W-1:0] irq_status
);
   localparam int AW = $clog2(MEM_DEPTH);
   localparam int SW = 14;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [SW-1:0] sy1_q, sy2_q, sy3_q;
   logic [SW-1:0] pin_now;
   logic cs_n, rd_n, wr_n, rstp_n, role_pin;
   logic cs_n_p, wr_n_p, sel_p;
   logic [7:0] din_p;

   assign pin_now = {pins.chip_select_n, pins.read_strobe_n,
                     pins.write_strobe_n, pins.pointer_or_data_select,
                     pins.reset_n_in, pins.role_select, pins.data_bus};

   // third stage keeps the values seen while the strobe was still low
   always_ff @(posedge clk) begin
      sy1_q <= pin_now;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
   end

   assign cs_n = sy2_q[13];
   assign rd_n = sy2_q[12];
   assign wr_n = sy2_q[11];
   assign rstp_n = sy2_q[9];
   assign role_pin = sy2_q[8];
   assign cs_n_p = sy3_q[13];
   assign wr_n_p = sy3_q[11];
   assign sel_p = sy3_q[10];
   assign din_p = sy3_q[7:0];

   // ****************************************
   // write decode
   // ****************************************
   logic wr_done;
   logic [7:0] ptr_q, ptr_d;
   logic hit_role, hit_en, hit_stat, hit_mem;

   // rising edge with chip select low in the sample just before it; the latched copy
   // avoids data hold races at the edge itself
   assign wr_done = wr_n && !wr_n_p && !cs_n_p && rstp_n;
   assign hit_role = wr_done && sel_p && (ptr_q == ROLE_CTRL_ADDR);
   assign hit_en = wr_done && sel_p && (ptr_q == IRQ_ENABLE_ADDR);
   assign hit_stat = wr_done && sel_p && (ptr_q == IRQ_STATUS_ADDR);
   assign hit_mem = wr_done && sel_p && !hit_role && !hit_en && !hit_stat;

   // pointer has no auto increment; each access is addressed explicitly
   always_comb begin
      ptr_d = ptr_q;
      if (!rstp_n) begin
         ptr_d = 8'h00;
      end else if (wr_done && !sel_p) begin
         ptr_d = din_p;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptr_q <= 8'h00;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   // ****************************************
   // memory
   // ****************************************
   logic [7:0] mem_q [MEM_DEPTH];
   logic [7:0] mem_d [MEM_DEPTH];

   // contents are not cleared by reset, as in a real buffer ram
   always_comb begin
      mem_d = mem_q;
      if (hit_mem) begin
         mem_d[ptr_q[AW-1:0]] = din_p;
      end
   end

   always_ff @(posedge clk) begin
      mem_q <= mem_d;
   end

   // ****************************************
   // role and interrupt registers
   // ****************************************
   logic role_q, role_d;
   logic [IRQ_W-1:0] en_q, en_d;
   logic [IRQ_W-1:0] stat_q, stat_d;
   logic irq_q, irq_d;

   always_comb begin
      role_d = role_q;
      en_d = en_q;
      stat_d = stat_q;
      if (!rstp_n) begin
         role_d = role_pin;
         en_d = IRQ_ENABLE_RESET;
         stat_d = '0;
      end else begin
         // pin not looked at here, so later changes do nothing
         if (hit_role) begin
            role_d = din_p[ROLE_BIT];
         end
         if (hit_en) begin
            en_d = din_p;
         end
         if (hit_stat) begin
            stat_d = stat_q & ~din_p;
         end
         stat_d = stat_d | event_pulse;
      end
      // no polarity control exists on purpose
      irq_d = |(stat_q & en_q);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         role_q <= ROLE_RESET;
         en_q <= IRQ_ENABLE_RESET;
         stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         role_q <= role_d;
         en_q <= en_d;
         stat_q <= stat_d;
         irq_q <= irq_d;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   logic [7:0] rdata_q, rdata_d;
   logic oe_q, oe_d;

   // pointer must already hold the target; reads never move it
   always_comb begin
      if (ptr_q == ROLE_CTRL_ADDR) begin
         rdata_d = {7'h00, role_q};
      end else if (ptr_q == IRQ_ENABLE_ADDR) begin
         rdata_d = en_q;
      end else if (ptr_q == IRQ_STATUS_ADDR) begin
         rdata_d = stat_q;
      end else begin
         rdata_d = mem_q[ptr_q[AW-1:0]];
      end
      oe_d = !cs_n && !rd_n && rstp_n;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         oe_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         oe_q <= oe_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign pins.data_from_dev = rdata_q;
   assign pins.data_dev_oe = oe_q;
   assign pins.irq_out = irq_q;
   assign role_peripheral = role_q;
   assign irq_status = stat_q;
endmodule : ihbp_device
`default_nettype wire

/* File: tb/ihbp_props.sv */
// pin checks for the port, host and device ends joined
// assumes the bench instantiates it beside the interface
`timescale 1ns/1ns
`default_nettype none
module ihbp_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic reset_n_in,
   input wire logic data_dev_oe,
   input wire logic data_host_oe
);
   // ****************************************
   // helper counts
   // ****************************************
   logic [5:0] low_q;
   logic [5:0] low_d;
   logic [5:0] high_q;
   logic [5:0] high_d;
   logic rd_sel;
   assign rd_sel = !chip_select_n && !read_strobe_n;
   // saturate so long runs never wrap
   always_comb begin
      low_d = (!rst_n || reset_n_in) ? 6'h00 : low_q + {5'h00, low_q != 6'h3F};
      high_d = (!rst_n || !reset_n_in) ? 6'h00 : high_q + {5'h00, high_q != 6'h3F};
   end
   always_ff @(posedge clk) begin
      low_q <= low_d;
      high_q <= high_d;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ****************************************
   // assertions
   // ****************************************
   a_reset_hold: assert property ($rose(reset_n_in) |-> low_q >= 6'h10)
      else $error("device reset pin held too short");
   a_reset_wait: assert property ($fell(chip_select_n) |-> high_q >= 6'h10)
      else $error("access too soon after reset");
   a_one_driver: assert property (!(data_dev_oe && data_host_oe))
      else $error("both ends drive the data bus");
   a_oe_needs_read: assert property (data_dev_oe |->
      ($past(rd_sel, 2) || $past(rd_sel, 3) || $past(rd_sel, 4)))
      else $error("device drives without selected read");
   a_oe_released: assert property ((!rd_sel)[*5] |-> !data_dev_oe)
      else $error("device keeps driving after read");
   a_read_drives: assert property ((rd_sel && reset_n_in)[*5] |-> data_dev_oe)
      else $error("device silent in selected read");
   a_write_held: assert property ($fell(write_strobe_n) |->
      (!write_strobe_n && !chip_select_n && data_host_oe)[*8])
      else $error("write strobe too short");
   a_read_held: assert property ($fell(read_strobe_n) |->
      (!read_strobe_n && !chip_select_n)[*8])
      else $error("read strobe too short");
endmodule : ihbp_props
`default_nettype wire

/* File: tb/indexed_host_bus_port_tb.sv */
// bench: host end drives device end through the pin interface
// assumes one clock and the package constants
`timescale 1ns/1ns
`default_nettype none
module indexed_host_bus_port_tb;
   import ihbp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic role_strap = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic cmd_sel = 1'b0;
   logic [7:0] cmd_wdata = 8'h00;
   logic [7:0] event_pulse = 8'h00;
   logic [7:0] rsp_data;
   logic [7:0] irq_status;
   logic cmd_ready;
   logic rsp_valid;
   logic link_ready;
   logic role_peripheral;
   logic irq_seen;
   int fails = 0;
   int compares = 0;
   ihbp_if pins();
   always #4 clk = ~clk;
   ihbp_host i_ihbp_host (.clk(clk), .rst_n(rst_n), .pins(pins), .role_strap(role_strap),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
      .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .link_ready(link_ready), .irq_seen(irq_seen));
   ihbp_device i_ihbp_device (.clk(clk), .rst_n(rst_n), .pins(pins),
      .event_pulse(event_pulse), .role_peripheral(role_peripheral), .irq_status(irq_status));
   ihbp_props i_ihbp_props (.clk(clk), .rst_n(rst_n), .chip_select_n(pins.chip_select_n),
      .read_strobe_n(pins.read_strobe_n), .write_strobe_n(pins.write_strobe_n),
      .reset_n_in(pins.reset_n_in), .data_dev_oe(pins.data_dev_oe),
      .data_host_oe(pins.data_host_oe));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic end_sim;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tmo(input string what);
      fails++;
      $display("wrong value %s expected done seen timeout", what);
      end_sim();
   endtask : tmo
   // one command; returns at the edge that takes it
   task automatic send(input logic w, input logic s, input logic [7:0] d);
      int n;
      @(posedge clk);
      cmd_write <= w;
      cmd_sel <= s;
      cmd_wdata <= d;
      cmd_valid <= 1'b1;
      n = 0;
      do begin @(negedge clk); n++; end while (cmd_ready !== 1'b1 && n < 200);
      if (n >= 200) tmo("cmd_ready");
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask : send
   task automatic rd(input logic [7:0] exp, input string what);
      int n;
      send(1'b0, 1'b1, 8'h00);
      n = 0;
      do begin @(negedge clk); n++; end while (rsp_valid !== 1'b1 && n < 30);
      if (n >= 30) tmo("rsp_valid");
      chk(what, exp, rsp_data);
   endtask : rd
   // pointer write, data write, then let the update land
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      send(1'b1, 1'b0, ptr);
      send(1'b1, 1'b1, d);
      repeat (16) @(posedge clk);
   endtask : wr
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_start;
      int n;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      n = 0;
      do begin @(negedge clk); n++; end while (link_ready !== 1'b1 && n < 60);
      if (n >= 60) tmo("link_ready");
      chk("role from pin", 8'h01, {7'h00, role_peripheral});
      chk("idle bus", 8'hFF, pins.data_bus);
      @(posedge clk);
      role_strap <= 1'b0;
      repeat (20) @(posedge clk);
      chk("role keeps", 8'h01, {7'h00, role_peripheral});
   endtask : t_start
   task automatic t_mem;
      wr(8'h20, 8'hA5);
      wr(8'h21, 8'h3C);
      send(1'b1, 1'b0, 8'h20);
      rd(8'hA5, "mem 20");
      rd(8'hA5, "mem 20 again");
      send(1'b1, 1'b0, 8'h21);
      rd(8'h3C, "mem 21");
   endtask : t_mem
   // role register read through the pointer before and after a write
   task automatic t_role;
      send(1'b1, 1'b0, ROLE_CTRL_ADDR);
      rd(8'h01, "role read");
      wr(ROLE_CTRL_ADDR, 8'h00);
      chk("role by write", 8'h00, {7'h00, role_peripheral});
      rd(8'h00, "role read back");
   endtask : t_role
   // bit 2 enabled, bit 0 not: only bit 2 holds the line
   task automatic t_irq;
      wr(IRQ_ENABLE_ADDR, 8'h04);
      event_pulse <= 8'h05;
      @(posedge clk);
      event_pulse <= 8'h00;
      repeat (4) @(negedge clk);
      chk("irq raised", 8'h01, {7'h00, pins.irq_out});
      chk("status set", 8'h05, irq_status);
      chk("irq seen", 8'h01, {7'h00, irq_seen});
      wr(IRQ_STATUS_ADDR, 8'h01);
      chk("irq held", 8'h01, {7'h00, pins.irq_out});
      chk("status part", 8'h04, irq_status);
      rd(8'h04, "status read");
      send(1'b1, 1'b1, 8'h04);
      repeat (16) @(negedge clk);
      chk("irq cleared", 8'h00, {7'h00, pins.irq_out});
      chk("irq seen clear", 8'h00, {7'h00, irq_seen});
   endtask : t_irq
   initial begin
      t_start();
      t_mem();
      t_role();
      t_irq();
      end_sim();
   end
endmodule : indexed_host_bus_port_tb
`default_nettype wire
